// *** rtl/dsc_regs.svh ***
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
// clock and conversion of nanoseconds to cycles
`define DSC_CLK_NS              8
`define DSC_CEIL_CYC(ns)        (((ns) + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_FLOOR_CYC(ns)       ((ns) / `DSC_CLK_NS)
// memory timing, slowest speed grade so every grade is served
`define DSC_T_RAH_NS            10
`define DSC_T_RCD_NS            20
`define DSC_T_CAC_NS            20
`define DSC_T_RAC_NS            80
`define DSC_T_CAS_NS            20
`define DSC_T_CP_NS             10
`define DSC_T_RP_NS             60
`define DSC_T_RAS_NS            80
`define DSC_T_CSR_NS            10
`define DSC_T_CWD_NS            50
`define DSC_T_RWD_NS            110
`define DSC_T_CWL_NS            20
`define DSC_T_OED_NS            20
`define DSC_T_RPS_NS            150
`define DSC_T_RASS_NS           100000
`define DSC_T_POWERUP_NS        200000
`define DSC_T_REF_ROW_NS        15625
// counts of cycles
`define DSC_RAH_CYC             `DSC_CEIL_CYC(`DSC_T_RAH_NS)
`define DSC_RCD_CYC             `DSC_CEIL_CYC(`DSC_T_RCD_NS)
`define DSC_CAC_CYC             `DSC_CEIL_CYC(`DSC_T_CAC_NS)
`define DSC_RAC_CYC             `DSC_CEIL_CYC(`DSC_T_RAC_NS)
`define DSC_CAS_CYC             `DSC_CEIL_CYC(`DSC_T_CAS_NS)
`define DSC_CP_CYC              `DSC_CEIL_CYC(`DSC_T_CP_NS)
`define DSC_RP_CYC              `DSC_CEIL_CYC(`DSC_T_RP_NS)
`define DSC_RAS_CYC             `DSC_CEIL_CYC(`DSC_T_RAS_NS)
`define DSC_CSR_CYC             `DSC_CEIL_CYC(`DSC_T_CSR_NS)
`define DSC_CWD_CYC             `DSC_CEIL_CYC(`DSC_T_CWD_NS)
`define DSC_RWD_CYC             `DSC_CEIL_CYC(`DSC_T_RWD_NS)
`define DSC_CWL_CYC             `DSC_CEIL_CYC(`DSC_T_CWL_NS)
`define DSC_OED_CYC             `DSC_CEIL_CYC(`DSC_T_OED_NS)
`define DSC_RPS_CYC             `DSC_CEIL_CYC(`DSC_T_RPS_NS)
// initialisation and refresh counts
`define DSC_INIT_REFRESHES      8
`define DSC_ROWS                512
`endif

// *** rtl/dsc_pkg.sv ***
package dsc_pkg;
  typedef enum logic [12:0] {
    DSC_POWER = 13'h0001,
    DSC_IDLE  = 13'h0002,
    DSC_ROW   = 13'h0004,
    DSC_COLA  = 13'h0008,
    DSC_CAS   = 13'h0010,
    DSC_WR    = 13'h0020,
    DSC_CEND  = 13'h0040,
    DSC_PRE   = 13'h0080,
    DSC_REFC  = 13'h0100,
    DSC_REFR  = 13'h0200,
    DSC_SRC   = 13'h0400,
    DSC_SRR   = 13'h0800,
    DSC_SRX   = 13'h1000
  } dsc_state_t;
endpackage

// *** rtl/dsc_ctrl.sv ***
`timescale 1ns/1ps
`include "dsc_regs.svh"
// Notes on behaviour
// - self refresh entry holds row and column strobes low at least 100 us
// - after self refresh, row strobe stays high the post precharge time
// - column strobe rises with, never over 50 ns before, row strobe rise
// - write strobe stays high through the end of every read
// - the enabled column strobes fall together and stay low well over 5 ns
// - write data is valid before the column fall in writes and from the write fall on in read-modify-write
// - read-modify-write waits 110 ns from row strobe fall to write
// - read-modify-write waits 50 ns from column fall to write
// - page cycles of read, write and read-modify-write may mix
// - read data is sampled only after the access times have passed
// - late column strobe is allowed; read then limited by column access
// - column address is presented before column precharge ends
// - column address stays valid 40 ns before row strobe rises
// - after self refresh, a burst of all 512 row refreshes runs
// - after power up wait 200 us then eight refresh row cycles
module dsc_ctrl #(
  parameter int POWERUP_CYC = `DSC_CEIL_CYC(`DSC_T_POWERUP_NS),
  parameter int RASS_CYC    = `DSC_CEIL_CYC(`DSC_T_RASS_NS),
  parameter int REF_ROW_CYC = `DSC_FLOOR_CYC(`DSC_T_REF_ROW_NS)
) (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic        req_write_in,
  input  wire logic        req_rmw_in,
  input  wire logic [17:0] req_addr_in,
  input  wire logic [15:0] req_wdata_in,
  input  wire logic [1:0]  req_lanes_in,
  output logic             rsp_valid_out,
  output logic [15:0]      rsp_rdata_out,
  input  wire logic        self_refresh_req_in,
  output logic             self_refresh_out,
  output logic             init_done_out,
  output logic             row_strobe_n_out,
  output logic             upper_lane_col_strobe_n_out,
  output logic             lower_lane_col_strobe_n_out,
  output logic             write_strobe_n_out,
  output logic             output_enable_n_out,
  output logic [8:0]       muxed_address_out,
  input  wire logic [15:0] data_lines_in,
  output logic [15:0]      data_lines_out,
  output logic             data_lines_oe_out
);
  ////////////////////////////////////////////////////////////////////////
  dsc_pkg::dsc_state_t state, next_state;
  logic [14:0] wait_cnt, next_wait_cnt;
  logic [7:0]  ras_cnt, next_ras_cnt;
  logic [9:0]  ref_left, next_ref_left;
  logic [10:0] ref_timer, next_ref_timer;
  logic        ref_pending, next_ref_pending;
  logic        init_done, next_init_done;
  logic        op_write, next_op_write;
  logic        op_rmw, next_op_rmw;
  logic [17:0] op_addr, next_op_addr;
  logic [15:0] op_wdata, next_op_wdata;
  logic [1:0]  op_lanes, next_op_lanes;
  logic        rsp_valid, next_rsp_valid;
  logic [15:0] rdata, next_rdata;
  logic        ras_n, next_ras_n;
  logic [1:0]  cas_n, next_cas_n;
  logic        we_n, next_we_n;
  logic        oe_n, next_oe_n;
  logic [8:0]  addr, next_addr;
  logic [15:0] dq, next_dq;
  logic        dq_oe, next_dq_oe;
  logic        accept, page_hit, ras_ok;

  // a page is only kept while no refresh is due, which also bounds the
  // page row-strobe pulse far below its maximum
  assign page_hit = req_valid_in && !ref_pending
                    && req_addr_in[17:9] == op_addr[17:9];
  assign req_ready_out = (state == dsc_pkg::DSC_IDLE && !ref_pending
                          && !self_refresh_req_in)
                         || (state == dsc_pkg::DSC_CEND && wait_cnt == 15'h0000
                             && ras_ok && page_hit);
  assign accept = req_valid_in && req_ready_out;
  assign ras_ok = ras_cnt >= 8'(`DSC_RAS_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state       = state;
    next_wait_cnt    = (wait_cnt != 15'h0000) ? wait_cnt - 15'h0001 : wait_cnt;
    next_ras_cnt     = (ras_cnt != 8'hFF) ? ras_cnt + 8'h01 : ras_cnt;
    next_ref_left    = ref_left;
    next_ref_timer   = ref_timer - 11'h001;
    next_ref_pending = ref_pending;
    next_init_done   = init_done;
    next_op_write    = op_write;
    next_op_rmw      = op_rmw;
    next_op_addr     = op_addr;
    next_op_wdata    = op_wdata;
    next_op_lanes    = op_lanes;
    next_rsp_valid   = 1'b0;
    next_rdata       = rdata;
    if (accept) begin
      next_op_write = req_write_in;
      next_op_rmw   = req_rmw_in && !req_write_in;
      next_op_addr  = req_addr_in;
      next_op_wdata = req_wdata_in;
      next_op_lanes = req_lanes_in;
    end
    case (state)
      dsc_pkg::DSC_POWER: begin
        if (wait_cnt == 15'h0000) begin
          next_ref_left = 10'(`DSC_INIT_REFRESHES);
          next_state    = dsc_pkg::DSC_REFC;
          next_wait_cnt = 15'(`DSC_CSR_CYC - 1);
        end
      end
      dsc_pkg::DSC_IDLE: begin
        if (ref_pending) begin
          next_ref_left = 10'h001;
          next_state    = dsc_pkg::DSC_REFC;
          next_wait_cnt = 15'(`DSC_CSR_CYC - 1);
        end else if (self_refresh_req_in) begin
          next_state    = dsc_pkg::DSC_SRC;
          next_wait_cnt = 15'(`DSC_CSR_CYC - 1);
        end else if (accept) begin
          next_state    = dsc_pkg::DSC_ROW;
          next_ras_cnt  = 8'h00;
          next_wait_cnt = 15'(`DSC_RAH_CYC - 1);
        end
      end
      dsc_pkg::DSC_ROW: begin
        // row address held, column address follows only afterwards
        if (wait_cnt == 15'h0000) begin
          next_state    = dsc_pkg::DSC_COLA;
          next_wait_cnt = 15'(`DSC_RCD_CYC - `DSC_RAH_CYC);
        end
      end
      dsc_pkg::DSC_COLA: begin
        if (wait_cnt == 15'h0000) begin
          next_state    = dsc_pkg::DSC_CAS;
          next_wait_cnt = op_rmw ? 15'(`DSC_CWD_CYC - 1)
                                 : 15'(`DSC_CAS_CYC - 1);
        end
      end
      dsc_pkg::DSC_CAS: begin
        // reads wait for both column and row access; late column strobe
        // simply makes the row term already satisfied
        if (wait_cnt == 15'h0000
            && (op_write || ras_cnt >= 8'(`DSC_RAC_CYC - 1))
            && (!op_rmw || ras_cnt >= 8'(`DSC_RWD_CYC - 1))) begin
          if (!op_write) begin
            next_rdata     = data_lines_in;
            next_rsp_valid = 1'b1;
          end
          next_state    = op_rmw ? dsc_pkg::DSC_WR : dsc_pkg::DSC_CEND;
          next_wait_cnt = op_rmw ? 15'(`DSC_OED_CYC + `DSC_CWL_CYC - 1)
                                 : 15'(`DSC_CP_CYC - 1);
        end
      end
      dsc_pkg::DSC_WR: begin
        if (wait_cnt == 15'h0000) begin
          next_state    = dsc_pkg::DSC_CEND;
          next_wait_cnt = 15'(`DSC_CP_CYC - 1);
        end
      end
      dsc_pkg::DSC_CEND: begin
        if (wait_cnt == 15'h0000 && ras_ok) begin
          if (page_hit) begin
            next_state    = dsc_pkg::DSC_COLA;
            next_wait_cnt = 15'h0000;
          end else begin
            next_state    = dsc_pkg::DSC_PRE;
            next_wait_cnt = 15'(`DSC_RP_CYC - 1);
          end
        end
      end
      dsc_pkg::DSC_PRE: begin
        if (wait_cnt == 15'h0000) begin
          next_wait_cnt = 15'(`DSC_CSR_CYC - 1);
          next_state    = (ref_left != 10'h000) ? dsc_pkg::DSC_REFC
                                                : dsc_pkg::DSC_IDLE;
          if (ref_left == 10'h000 && !init_done) begin
            next_init_done = 1'b1;
          end
        end
      end
      dsc_pkg::DSC_REFC: begin
        if (wait_cnt == 15'h0000) begin
          next_state       = dsc_pkg::DSC_REFR;
          next_ras_cnt     = 8'h00;
          next_ref_left    = ref_left - 10'h001;
          next_ref_pending = 1'b0;
          next_wait_cnt    = 15'(`DSC_RAS_CYC - 1);
        end
      end
      dsc_pkg::DSC_REFR: begin
        if (wait_cnt == 15'h0000) begin
          next_state    = dsc_pkg::DSC_PRE;
          next_wait_cnt = 15'(`DSC_RP_CYC - 1);
        end
      end
      dsc_pkg::DSC_SRC: begin
        if (wait_cnt == 15'h0000) begin
          next_state    = dsc_pkg::DSC_SRR;
          next_wait_cnt = 15'(RASS_CYC - 1);
        end
      end
      dsc_pkg::DSC_SRR: begin
        if (wait_cnt == 15'h0000 && !self_refresh_req_in) begin
          next_state    = dsc_pkg::DSC_SRX;
          next_wait_cnt = 15'(`DSC_RPS_CYC - 1);
        end
      end
      dsc_pkg::DSC_SRX: begin
        if (wait_cnt == 15'h0000) begin
          next_ref_left    = 10'(`DSC_ROWS);
          next_ref_pending = 1'b0;
          next_state       = dsc_pkg::DSC_REFC;
          next_wait_cnt    = 15'(`DSC_CSR_CYC - 1);
        end
      end
      default: begin
        next_state    = dsc_pkg::DSC_IDLE;
        next_wait_cnt = 15'h0000;
      end
    endcase

    // a refresh coming due wins over a clear in the same cycle, so no
    // interval is lost when a refresh slot and the timer coincide
    if (ref_timer == 11'h000) begin
      next_ref_timer   = 11'(REF_ROW_CYC - 1);
      next_ref_pending = init_done;
    end

    // pin values follow the state being entered
    next_ras_n = 1'b1;
    next_cas_n = 2'b11;
    next_we_n  = 1'b1;
    next_oe_n  = 1'b1;
    next_addr  = addr;
    next_dq    = op_wdata;
    next_dq_oe = 1'b0;
    case (next_state)
      dsc_pkg::DSC_ROW: begin
        next_ras_n = 1'b0;
        next_addr  = next_op_addr[17:9];
      end
      dsc_pkg::DSC_COLA: begin
        next_ras_n = 1'b0;
        next_addr  = next_op_addr[8:0];
        next_we_n  = !next_op_write;
        next_dq    = next_op_wdata;
        next_dq_oe = next_op_write;
      end
      dsc_pkg::DSC_CAS: begin
        next_ras_n = 1'b0;
        // lanes fall on one edge; reads open both lanes
        next_cas_n = op_write ? ~op_lanes : 2'b00;
        next_we_n  = !op_write;
        next_oe_n  = op_write;
        next_dq_oe = op_write;
      end
      dsc_pkg::DSC_WR: begin
        next_ras_n = 1'b0;
        next_cas_n = 2'b00;
        // output enable lifted first so the lines are free before driving
        next_we_n  = !(next_wait_cnt < 15'(`DSC_CWL_CYC));
        next_dq_oe = next_wait_cnt < 15'(`DSC_CWL_CYC);
      end
      dsc_pkg::DSC_CEND: begin
        next_ras_n = 1'b0;
      end
      dsc_pkg::DSC_REFC: begin
        next_cas_n = 2'b00;
      end
      dsc_pkg::DSC_REFR, dsc_pkg::DSC_SRR: begin
        next_ras_n = 1'b0;
        next_cas_n = 2'b00;
      end
      dsc_pkg::DSC_SRC: begin
        next_cas_n = 2'b00;
      end
      default: begin
        // both strobes rise on one edge when self refresh ends
        next_ras_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state       <= dsc_pkg::DSC_POWER;
      wait_cnt    <= 15'(POWERUP_CYC - 1);
      ras_cnt     <= 8'h00;
      ref_left    <= 10'h000;
      ref_timer   <= 11'(REF_ROW_CYC - 1);
      ref_pending <= 1'b0;
      init_done   <= 1'b0;
      op_write    <= 1'b0;
      op_rmw      <= 1'b0;
      op_addr     <= 18'h00000;
      op_wdata    <= 16'h0000;
      op_lanes    <= 2'h0;
      rsp_valid   <= 1'b0;
      rdata       <= 16'h0000;
      ras_n       <= 1'b1;
      cas_n       <= 2'b11;
      we_n        <= 1'b1;
      oe_n        <= 1'b1;
      addr        <= 9'h000;
      dq          <= 16'h0000;
      dq_oe       <= 1'b0;
    end else if (clk_en_in) begin
      state       <= next_state;
      wait_cnt    <= next_wait_cnt;
      ras_cnt     <= next_ras_cnt;
      ref_left    <= next_ref_left;
      ref_timer   <= next_ref_timer;
      ref_pending <= next_ref_pending;
      init_done   <= next_init_done;
      op_write    <= next_op_write;
      op_rmw      <= next_op_rmw;
      op_addr     <= next_op_addr;
      op_wdata    <= next_op_wdata;
      op_lanes    <= next_op_lanes;
      rsp_valid   <= next_rsp_valid;
      rdata       <= next_rdata;
      ras_n       <= next_ras_n;
      cas_n       <= next_cas_n;
      we_n        <= next_we_n;
      oe_n        <= next_oe_n;
      addr        <= next_addr;
      dq          <= next_dq;
      dq_oe       <= next_dq_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign rsp_valid_out               = rsp_valid;
  assign rsp_rdata_out               = rdata;
  assign self_refresh_out            = state == dsc_pkg::DSC_SRR;
  assign init_done_out               = init_done;
  assign row_strobe_n_out            = ras_n;
  assign upper_lane_col_strobe_n_out = cas_n[1];
  assign lower_lane_col_strobe_n_out = cas_n[0];
  assign write_strobe_n_out          = we_n;
  assign output_enable_n_out         = oe_n;
  assign muxed_address_out           = addr;
  assign data_lines_out              = dq;
  assign data_lines_oe_out           = dq_oe;
endmodule

// *** dv/dsc_ctrl_checker.sv ***
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_ctrl_checker #(
  parameter int RASS_CYC = 12500
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic row_strobe_n_out,
  input wire logic upper_lane_col_strobe_n_out,
  input wire logic lower_lane_col_strobe_n_out,
  input wire logic write_strobe_n_out,
  input wire logic output_enable_n_out,
  input wire logic data_lines_oe_out,
  input wire logic self_refresh_out
);
  logic [15:0] ras_cnt, next_ras_cnt, rhi_cnt, next_rhi_cnt;
  logic [15:0] cas_cnt, next_cas_cnt;
  logic        sr_q, next_sr_q, sr_pend, next_sr_pend;
  logic        ras_n, we_n, oe_n, l_n, cas_low;
  assign ras_n = row_strobe_n_out;
  assign we_n = write_strobe_n_out;
  assign oe_n = output_enable_n_out;
  assign l_n = lower_lane_col_strobe_n_out;
  assign cas_low = !(upper_lane_col_strobe_n_out && l_n);
  //////////////////////////////////////////////////////////////////////////
  // sr_pend marks the first row fall after a self refresh exit
  always_comb begin
    next_ras_cnt = ras_n ? 16'h0000 : ras_cnt + 16'h0001;
    next_rhi_cnt = ras_n ? rhi_cnt + 16'h0001 : 16'h0000;
    next_cas_cnt = cas_low ? cas_cnt + 16'h0001 : 16'h0000;
    next_sr_q = self_refresh_out;
    next_sr_pend = sr_pend;
    if (sr_q && !self_refresh_out) begin
      next_sr_pend = 1'b1;
    end else if (!ras_n) begin
      next_sr_pend = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ras_cnt <= 16'h0000;
      rhi_cnt <= 16'h0000;
      cas_cnt <= 16'h0000;
      sr_q <= 1'b0;
      sr_pend <= 1'b0;
    end else begin
      ras_cnt <= next_ras_cnt;
      rhi_cnt <= next_rhi_cnt;
      cas_cnt <= next_cas_cnt;
      sr_q <= next_sr_q;
      sr_pend <= next_sr_pend;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_col_fall; $rose(cas_low); endsequence
  sequence s_rmw_write; $fell(we_n) && cas_low; endsequence
  property p_ras_to_cas;
    (s_col_fall ##0 !ras_n) |-> ras_cnt >= `DSC_RCD_CYC;
  endproperty
  property p_cas_width; s_col_fall |-> cas_low [*3]; endproperty
  property p_csr; $fell(ras_n) && cas_low |-> cas_cnt >= `DSC_CSR_CYC;
  endproperty
  property p_rwd; s_rmw_write |-> ras_cnt >= `DSC_RWD_CYC; endproperty
  property p_cwd; s_rmw_write |-> cas_cnt >= `DSC_CWD_CYC; endproperty
  property p_sr_entry; $fell(self_refresh_out) |-> ras_cnt >= RASS_CYC;
  endproperty
  property p_sr_exit; $rose(l_n) && !ras_n |-> !$past(self_refresh_out);
  endproperty
  property p_sr_pre; $fell(ras_n) && sr_pend |-> rhi_cnt >= `DSC_RPS_CYC;
  endproperty
  property p_read_we; $rose(l_n) && !$past(oe_n) |-> we_n && $past(we_n);
  endproperty
  property p_wr_drive; !we_n && cas_low |-> data_lines_oe_out; endproperty
  a_ras_to_cas: assert property (p_ras_to_cas)
    else $error("column fall too soon after row fall");
  a_cas_width: assert property (p_cas_width)
    else $error("column strobe low too briefly");
  a_csr: assert property (p_csr)
    else $error("column setup before refresh row fall too short");
  a_rwd: assert property (p_rwd)
    else $error("write fall too soon after row fall");
  a_cwd: assert property (p_cwd)
    else $error("write fall too soon after column fall");
  a_sr_entry: assert property (p_sr_entry)
    else $error("self refresh held too briefly");
  a_sr_exit: assert property (p_sr_exit)
    else $error("column rose before row on self refresh exit");
  a_sr_pre: assert property (p_sr_pre)
    else $error("precharge after self refresh too short");
  a_read_we: assert property (p_read_we)
    else $error("write strobe low at end of read");
  a_wr_drive: assert property (p_wr_drive)
    else $error("write data not driven");
endmodule

bind dsc_ctrl dsc_ctrl_checker #(.RASS_CYC(RASS_CYC)) u_chk (
  .sys_clk_in                  (sys_clk_in),
  .reset_n_in                  (reset_n_in),
  .row_strobe_n_out            (row_strobe_n_out),
  .upper_lane_col_strobe_n_out (upper_lane_col_strobe_n_out),
  .lower_lane_col_strobe_n_out (lower_lane_col_strobe_n_out),
  .write_strobe_n_out          (write_strobe_n_out),
  .output_enable_n_out         (output_enable_n_out),
  .data_lines_oe_out           (data_lines_oe_out),
  .self_refresh_out            (self_refresh_out)
);

// *** dv/dsc_mem_model.sv ***
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_mem_model (
  input wire logic        clk_in,
  input wire logic        row_strobe_n_in,
  input wire logic        upper_lane_col_strobe_n_in,
  input wire logic        lower_lane_col_strobe_n_in,
  input wire logic        write_strobe_n_in,
  input wire logic        output_enable_n_in,
  input wire logic [8:0]  muxed_address_in,
  input wire logic [15:0] data_lines_in,
  input wire logic        data_lines_oe_in,
  output logic     [15:0] data_lines_out
);
  logic        r_n, u_n, l_n, pr = 1'b1, pu = 1'b1, pl = 1'b1;
  logic [8:0]  row = 9'h000, col = 9'h000;
  logic [15:0] mem [int];
  logic [15:0] w, wd, cur = 16'h0000, last = 16'h0000;
  int          ucnt = 0, lcnt = 0, refreshes = 0;
  assign r_n = row_strobe_n_in;
  assign u_n = upper_lane_col_strobe_n_in;
  assign l_n = lower_lane_col_strobe_n_in;
  // negedge sampling keeps the model clear of the controller's own edge
  always @(negedge clk_in) begin
    last = data_lines_out;
    if (pr && !r_n) begin
      if (!u_n || !l_n) refreshes++;
      else row = muxed_address_in;
    end
    if (pu && pl && !(u_n && l_n) && !r_n) col = muxed_address_in;
    if (!r_n && !write_strobe_n_in && !(u_n && l_n)) begin
      w = mem.exists(int'({row, col})) ? mem[int'({row, col})] : 16'h0000;
      wd = data_lines_oe_in ? data_lines_in : ~last;
      if (!u_n) w[15:8] = wd[15:8];
      if (!l_n) w[7:0] = wd[7:0];
      mem[int'({row, col})] = w;
    end
    ucnt = u_n ? 0 : ucnt + 1;
    lcnt = l_n ? 0 : lcnt + 1;
    cur = mem.exists(int'({row, col})) ? mem[int'({row, col})] : 16'h0000;
    pr = r_n;
    pu = u_n;
    pl = l_n;
  end
  // undriven or early data toggles so a premature sample shows up
  assign data_lines_out[15:8] = (!output_enable_n_in && !u_n &&
    ucnt >= `DSC_CAC_CYC) ? cur[15:8] : ~last[15:8];
  assign data_lines_out[7:0] = (!output_enable_n_in && !l_n &&
    lcnt >= `DSC_CAC_CYC) ? cur[7:0] : ~last[7:0];
endmodule

// *** dv/test_dram_strobe_sequencing.sv ***
`timescale 1ns/1ps
module test_dram_strobe_sequencing;
  logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, valid = 1'b0;
  logic        wr = 1'b0, rmw = 1'b0, sr_req = 1'b0;
  logic [1:0]  lanes = 2'b11;
  logic [17:0] addr = 18'h00000;
  logic [15:0] wdata = 16'h0000;
  logic        ready, rsp_v, sr, done, ras_n, u_n, l_n, we_n, oe_n, dq_oe;
  logic [8:0]  ma;
  logic [15:0] rdata, dq_out, dq_in, q;
  int          err_total = 0, comparisons = 0, rc, i;
  initial forever #4 clk = ~clk;
  dsc_ctrl #(.POWERUP_CYC(50), .RASS_CYC(40), .REF_ROW_CYC(300)) u_dut (
    .sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(clk_en),
    .req_valid_in(valid), .req_ready_out(ready), .req_write_in(wr),
    .req_rmw_in(rmw), .req_addr_in(addr), .req_wdata_in(wdata),
    .req_lanes_in(lanes), .rsp_valid_out(rsp_v), .rsp_rdata_out(rdata),
    .self_refresh_req_in(sr_req), .self_refresh_out(sr),
    .init_done_out(done), .row_strobe_n_out(ras_n),
    .upper_lane_col_strobe_n_out(u_n), .lower_lane_col_strobe_n_out(l_n),
    .write_strobe_n_out(we_n), .output_enable_n_out(oe_n),
    .muxed_address_out(ma), .data_lines_in(dq_in),
    .data_lines_out(dq_out), .data_lines_oe_out(dq_oe));
  dsc_mem_model u_mem (
    .clk_in(clk), .row_strobe_n_in(ras_n),
    .upper_lane_col_strobe_n_in(u_n), .lower_lane_col_strobe_n_in(l_n),
    .write_strobe_n_in(we_n), .output_enable_n_in(oe_n),
    .muxed_address_in(ma), .data_lines_in(dq_out),
    .data_lines_oe_in(dq_oe), .data_lines_out(dq_in));
  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang();
    err_total++;
    $display("wrong value wait expected done seen timeout");
    results();
  endtask
  task automatic check(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until taken at a rising edge with ready high
  task automatic send(input logic w, m, input logic [17:0] a,
                      input logic [15:0] d, input logic [1:0] ln);
    int k;
    @(posedge clk);
    valid <= 1'b1;
    wr <= w;
    rmw <= m;
    addr <= a;
    wdata <= d;
    lanes <= ln;
    for (k = 0; k < 400; k++) begin
      @(negedge clk);
      if (ready === 1'b1) break;
    end
    if (k == 400) hang();
    @(posedge clk);
    valid <= 1'b0;
  endtask
  task automatic rd(input logic m, input logic [17:0] a,
                    input logic [15:0] d, input int gap);
    int k;
    send(1'b0, m, a, d, 2'b11);
    if (gap > 0) begin
      clk_en <= 1'b0;
      repeat (gap) @(posedge clk);
      clk_en <= 1'b1;
    end
    for (k = 0; k < 100; k++) begin
      @(negedge clk);
      if (rsp_v === 1'b1) break;
    end
    if (k == 100) hang();
    q = rdata;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_init();
    for (i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clk);
    if (i == 2000) hang();
    check("init refreshes", 16'h0001, {15'h0, u_mem.refreshes >= 8});
  endtask
  task automatic t_rw();
    send(1'b1, 1'b0, 18'h00012, 16'hA55A, 2'b11);
    send(1'b1, 1'b0, 18'h00213, 16'h0FF0, 2'b11);
    rd(1'b0, 18'h00012, 16'h0000, 3);
    check("read row 0", 16'hA55A, q);
    rd(1'b0, 18'h00213, 16'h0000, 0);
    check("read row 1", 16'h0FF0, q);
  endtask
  task automatic t_lanes();
    send(1'b1, 1'b0, 18'h00420, 16'h1234, 2'b11);
    send(1'b1, 1'b0, 18'h00420, 16'hABCD, 2'b01);
    send(1'b1, 1'b0, 18'h00420, 16'h5600, 2'b10);
    rd(1'b0, 18'h00420, 16'h0000, 0);
    check("lane merge", 16'h56CD, q);
  endtask
  task automatic t_rmw();
    send(1'b1, 1'b0, 18'h00630, 16'hCAFE, 2'b11);
    rd(1'b1, 18'h00630, 16'hBEEF, 0);
    check("rmw old", 16'hCAFE, q);
    rd(1'b0, 18'h00630, 16'h0000, 0);
    check("rmw new", 16'hBEEF, q);
  endtask
  task automatic t_sr();
    @(posedge clk);
    sr_req <= 1'b1;
    for (i = 0; i < 400 && sr !== 1'b1; i++) @(negedge clk);
    if (i == 400) hang();
    repeat (4) @(posedge clk);
    rc = u_mem.refreshes;
    repeat (60) @(posedge clk);
    sr_req <= 1'b0;
    for (i = 0; i < 30000 && u_mem.refreshes - rc < 512; i++) @(negedge clk);
    check("burst refresh", 16'h0001, {15'h0, i < 30000});
    rd(1'b0, 18'h00012, 16'h0000, 0);
    check("kept data", 16'hA55A, q);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_init();
    t_rw();
    t_lanes();
    t_rmw();
    t_sr();
    results();
  end
endmodule
